//--- dcdma_pkg.sv
// Package of constants for the dual channel byte DMA engine
package dcdma_pkg;
	// Register word indices (byte address = 4 * index)
	localparam logic [4:0] REG_SRC_LO = 5'h00;
	localparam logic [4:0] REG_SRC_HI = 5'h01;
	localparam logic [4:0] REG_DST_LO = 5'h02;
	localparam logic [4:0] REG_DST_HI = 5'h03;
	localparam logic [4:0] REG_CNT_LO = 5'h04;
	localparam logic [4:0] REG_CNT_HI = 5'h05;
	localparam logic [4:0] REG_CTRL = 5'h06;
	localparam logic [4:0] REG_CH_STRIDE = 5'h08;
	localparam logic [4:0] REG_POWER_CTRL = 5'h10;
	localparam logic [4:0] REG_EXT_CFG = 5'h11;
	// Channel control field positions
	localparam int CTRL_GO = 0;
	localparam int CTRL_DONE = 1;
	localparam int CTRL_TRANSFER_SEL = 2;
	localparam int CTRL_DEMAND_SEL = 3;
	localparam int CTRL_SRC_INC = 4;
	localparam int CTRL_SRC_SPACE = 5;
	localparam int CTRL_DST_INC = 6;
	localparam int CTRL_DST_SPACE = 7;
	localparam logic [7:0] CTRL_RESET = 8'h00;
	// Power control: bus hold role bits
	localparam int POWER_CONTROL_REG_REQ = 0;
	localparam int POWER_CONTROL_REG_ARB = 1;
	localparam logic [1:0] POWER_CONTROL_REG_RESET = 2'h0;
	localparam logic [1:0] EXT_CFG_RESET = 2'h0;
	// Operating modes {demand_sel, transfer_sel}
	localparam logic [1:0] MODE_ALT = 2'h0;
	localparam logic [1:0] MODE_BURST = 2'h1;
	localparam logic [1:0] MODE_SERIAL = 2'h2;
	localparam logic [1:0] MODE_EXT = 2'h3;
	// Timing: oscillator periods per machine cycle, core_clk is the oscillator
	localparam int OSC_PER_MC = 12;
	localparam logic [4:0] PH_SHORT = 5'(OSC_PER_MC / 2);
	localparam logic [4:0] PH_LONG = 5'(OSC_PER_MC);
	localparam logic [1:0] WAIT_AFTER_GO = 2'h2;
	localparam logic [1:0] WAIT_NEXT = 2'h1;
	// Transfer engine states
	typedef enum logic [3:0] {
		XS_IDLE = 4'b0001,
		XS_HOLD = 4'b0010,
		XS_READ = 4'b0100,
		XS_WRITE = 4'b1000
	} dcdma_xs_t;
endpackage : dcdma_pkg

//--- dcdma_top.sv
// Dual channel byte DMA engine with bus hold handshake and Avalon-MM registers
`timescale 1ns/10ps
module dcdma_top (
	input wire logic core_clk, // 25 MHz clock, also the oscillator
	input wire logic rst, // Asynchronous reset, active high
	input wire logic [4:0] avs_address, // Word address
	input wire logic avs_read, // Read request
	input wire logic avs_write, // Write request
	input wire logic [31:0] avs_writedata, // Write data, low byte used
	output logic [31:0] avs_readdata, // Read data
	output logic avs_waitrequest, // Low marks the accepting edge
	input wire logic instr_end, // Pulse: an instruction has completed
	input wire logic instr_last_mc, // Level: CPU in final machine cycle
	output logic cpu_suspend, // CPU must not execute
	input wire logic [3:0] ser_flags, // Local rx, local tx, global rx ne, global tx nf
	output logic [3:0] ser_flag_clr, // Pulse clearing the serving flag
	input wire logic [1:0] ext_irq_n, // External interrupt pins
	output logic [1:0] done_flag, // Completion flags, interrupt sources
	output logic [7:0] int_addr, // Internal RAM or SFR address
	output logic int_sfr_sel, // Internal access targets an SFR
	output logic int_rd, // Internal read pulse, data sampled at the edge ending the pulse
	output logic int_wr, // Internal write pulse
	output logic [7:0] int_wdata, // Internal write data
	input wire logic [7:0] int_rdata, // Internal read data
	input wire logic [7:0] port0_in, // Address/data bus pins in
	output logic [7:0] port0_out, // Address/data bus pins out
	output logic port0_oe, // Address/data bus drive enable
	output logic [7:0] port2_out, // High address pins
	output logic port2_oe, // High address drive enable
	output logic ale, // Address latch enable
	output logic rd_n, // External read strobe
	output logic wr_n, // External write strobe
	input wire logic hld_in, // Hold request pin in, active low
	output logic hld_out, // Hold request pin out, active low
	output logic hld_oe, // Hold request drive enable
	input wire logic bus_hold_ack_in, // Hold acknowledge pin in, active low
	output logic bus_hold_ack_out, // Hold acknowledge pin out, active low
	output logic bus_hold_ack_oe // Hold acknowledge drive enable
);
	logic [1:0] ext_s1_reg, ext_s2_reg, ext_d_reg;
	logic [1:0] hld_s1_reg, hld_s2_reg;
	logic [1:0] bus_hold_ack_s1_reg, bus_hold_ack_s2_reg;
	logic [7:0] p0_s1_reg, p0_s2_reg;
	logic [15:0] sar_reg [2];
	logic [15:0] dar_reg [2];
	logic [15:0] bcr_reg [2];
	logic [7:0] ctrl_reg [2];
	logic [1:0] wait_reg [2];
	logic [1:0] pend_reg, cont_reg, ready, ext_need;
	logic [1:0] power_control_reg_reg, ext_edge_reg;
	logic wr_acc;
	dcdma_pkg::dcdma_xs_t xs_reg;
	logic cur_reg, src_ext_reg, dst_ext_reg, hi_seen_reg, grant_reg;
	logic [1:0] upd_reg;
	logic [4:0] tcnt_reg, plen;
	logic [7:0] data_reg;
	logic [3:0] clr_sel_reg;
	logic start, pick, ext_any, blocked;

	// Two-flop synchronisers on every pin input
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			ext_s1_reg <= 2'h3;
			ext_s2_reg <= 2'h3;
			ext_d_reg <= 2'h3;
			hld_s1_reg <= 2'h3;
			hld_s2_reg <= 2'h3;
			bus_hold_ack_s1_reg <= 2'h3;
			bus_hold_ack_s2_reg <= 2'h3;
			p0_s1_reg <= 8'h00;
			p0_s2_reg <= 8'h00;
		end else begin
			ext_s1_reg <= ext_irq_n;
			ext_s2_reg <= ext_s1_reg;
			ext_d_reg <= ext_s2_reg;
			hld_s1_reg <= {1'b1, hld_in};
			hld_s2_reg <= hld_s1_reg;
			bus_hold_ack_s1_reg <= {1'b1, bus_hold_ack_in};
			bus_hold_ack_s2_reg <= bus_hold_ack_s1_reg;
			p0_s1_reg <= port0_in;
			p0_s2_reg <= p0_s1_reg;
		end
	end

	// Bus slave: waitrequest drops one clock after a request, access takes effect then
	assign wr_acc = avs_write & ~avs_waitrequest;
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			avs_waitrequest <= 1'b1;
			avs_readdata <= 32'h0000_0000;
		end else begin
			avs_waitrequest <= ~((avs_read | avs_write) & avs_waitrequest);
			if ((avs_read | avs_write) & avs_waitrequest) begin
				avs_readdata <= 32'h0000_0000;
				if (avs_address == dcdma_pkg::REG_POWER_CTRL)
					avs_readdata <= {30'h0, power_control_reg_reg};
				else if (avs_address == dcdma_pkg::REG_EXT_CFG)
					avs_readdata <= {30'h0, ext_edge_reg};
				else if (avs_address[4] == 1'b0) begin
					case (avs_address[2:0])
						3'h0: avs_readdata <= {24'h0, sar_reg[avs_address[3]][7:0]};
						3'h1: avs_readdata <= {24'h0, sar_reg[avs_address[3]][15:8]};
						3'h2: avs_readdata <= {24'h0, dar_reg[avs_address[3]][7:0]};
						3'h3: avs_readdata <= {24'h0, dar_reg[avs_address[3]][15:8]};
						3'h4: avs_readdata <= {24'h0, bcr_reg[avs_address[3]][7:0]};
						3'h5: avs_readdata <= {24'h0, bcr_reg[avs_address[3]][15:8]};
						3'h6: avs_readdata <= {24'h0, ctrl_reg[avs_address[3]]};
						default: avs_readdata <= 32'h0000_0000;
					endcase
				end
			end
		end
	end

	// Global registers: hold role and pin sensitivity
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			power_control_reg_reg <= dcdma_pkg::POWER_CONTROL_REG_RESET;
			ext_edge_reg <= dcdma_pkg::EXT_CFG_RESET;
		end else if (wr_acc) begin
			if (avs_address == dcdma_pkg::REG_POWER_CTRL)
				power_control_reg_reg <= avs_writedata[1:0];
			if (avs_address == dcdma_pkg::REG_EXT_CFG)
				ext_edge_reg <= avs_writedata[1:0];
		end
	end

	// Per-channel registers, triggers and pointer updates
	for (genvar c = 0; c < 2; c++) begin : g_ch
		logic [1:0] mode;
		logic wsel, trig, go_wr, last, fall;
		assign mode = ctrl_reg[c][dcdma_pkg::CTRL_DEMAND_SEL -: 2];
		assign wsel = wr_acc & (avs_address[4:3] == 2'(c));
		assign go_wr = wsel & (avs_address[2:0] == dcdma_pkg::REG_CTRL[2:0])
			& avs_writedata[dcdma_pkg::CTRL_GO] & ~ctrl_reg[c][dcdma_pkg::CTRL_GO];
		assign last = upd_reg[c] & (bcr_reg[c] == 16'h0001);
		assign fall = ext_d_reg[c] & ~ext_s2_reg[c];
		assign ext_need[c] = ~ctrl_reg[c][dcdma_pkg::CTRL_SRC_SPACE]
			| ~ctrl_reg[c][dcdma_pkg::CTRL_DST_SPACE];
		// Trigger source by mode
		always_comb begin
			case (mode)
				dcdma_pkg::MODE_SERIAL: trig = |ser_flags;
				dcdma_pkg::MODE_EXT: trig = ext_edge_reg[c] ? pend_reg[c] : ~ext_s2_reg[c];
				default: trig = 1'b1;
			endcase
		end
		assign ready[c] = ctrl_reg[c][dcdma_pkg::CTRL_GO] & trig
			& (cont_reg[c] | ((wait_reg[c] == dcdma_pkg::WAIT_NEXT) & instr_end))
			& ~(ext_need[c] & blocked);
		// Pointers, count and control
		always_ff @(posedge core_clk or posedge rst) begin
			if (rst) begin
				sar_reg[c] <= 16'h0000;
				dar_reg[c] <= 16'h0000;
				bcr_reg[c] <= 16'h0000;
				ctrl_reg[c] <= dcdma_pkg::CTRL_RESET;
			end else if (upd_reg[c]) begin
				if (ctrl_reg[c][dcdma_pkg::CTRL_SRC_INC])
					sar_reg[c] <= sar_reg[c] + 16'h0001;
				if (ctrl_reg[c][dcdma_pkg::CTRL_DST_INC])
					dar_reg[c] <= dar_reg[c] + 16'h0001;
				bcr_reg[c] <= bcr_reg[c] - 16'h0001;
				if (last) begin
					ctrl_reg[c][dcdma_pkg::CTRL_GO] <= 1'b0;
					ctrl_reg[c][dcdma_pkg::CTRL_DONE] <= 1'b1;
				end
			end else if (wsel) begin
				case (avs_address[2:0])
					3'h0: sar_reg[c][7:0] <= avs_writedata[7:0];
					3'h1: sar_reg[c][15:8] <= avs_writedata[7:0];
					3'h2: dar_reg[c][7:0] <= avs_writedata[7:0];
					3'h3: dar_reg[c][15:8] <= avs_writedata[7:0];
					3'h4: bcr_reg[c][7:0] <= avs_writedata[7:0];
					3'h5: bcr_reg[c][15:8] <= avs_writedata[7:0];
					3'h6: ctrl_reg[c] <= avs_writedata[7:0];
					default: ;
				endcase
			end
		end
		// Instruction waits, edge pending and back-to-back continuation
		always_ff @(posedge core_clk or posedge rst) begin
			if (rst) begin
				wait_reg[c] <= 2'h0;
				pend_reg[c] <= 1'b0;
				cont_reg[c] <= 1'b0;
			end else begin
				if (go_wr)
					wait_reg[c] <= dcdma_pkg::WAIT_AFTER_GO;
				else if (mode == dcdma_pkg::MODE_EXT && fall)
					wait_reg[c] <= instr_last_mc ? dcdma_pkg::WAIT_AFTER_GO
						: dcdma_pkg::WAIT_NEXT;
				else if (upd_reg[c])
					wait_reg[c] <= dcdma_pkg::WAIT_NEXT;
				else if (instr_end && wait_reg[c] > dcdma_pkg::WAIT_NEXT)
					wait_reg[c] <= wait_reg[c] - 2'h1;
				if (fall && ext_edge_reg[c])
					pend_reg[c] <= 1'b1;
				else if (start && pick == 1'(c))
					pend_reg[c] <= 1'b0;
				if (upd_reg[c])
					cont_reg[c] <= ~last & ((mode == dcdma_pkg::MODE_BURST)
						| ((mode == dcdma_pkg::MODE_EXT) & ~ext_edge_reg[c]));
				else if (~trig)
					cont_reg[c] <= 1'b0;
			end
		end
	end

	// Hold gating of external transfers in arbiter role
	assign blocked = power_control_reg_reg[dcdma_pkg::POWER_CONTROL_REG_ARB] & (grant_reg | ~hld_s2_reg[0]);
	assign pick = ~ready[0];
	assign start = (xs_reg == dcdma_pkg::XS_IDLE) & (|ready) & ~(|upd_reg);
	assign ext_any = src_ext_reg | dst_ext_reg;
	assign plen = (src_ext_reg & dst_ext_reg) ? dcdma_pkg::PH_LONG : dcdma_pkg::PH_SHORT;

	// Transfer engine: hold wait, read phase, write phase
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			xs_reg <= dcdma_pkg::XS_IDLE;
			cur_reg <= 1'b0;
			src_ext_reg <= 1'b0;
			dst_ext_reg <= 1'b0;
			tcnt_reg <= 5'h00;
			upd_reg <= 2'h0;
			data_reg <= 8'h00;
			clr_sel_reg <= 4'h0;
		end else begin
			upd_reg <= 2'h0;
			tcnt_reg <= tcnt_reg + 5'h01;
			case (xs_reg)
				dcdma_pkg::XS_IDLE: begin
					if (start) begin
						cur_reg <= pick;
						src_ext_reg <= ~ctrl_reg[pick][dcdma_pkg::CTRL_SRC_SPACE];
						dst_ext_reg <= ~ctrl_reg[pick][dcdma_pkg::CTRL_DST_SPACE];
						clr_sel_reg <= ser_flags & ~(ser_flags - 4'h1);
						tcnt_reg <= 5'h00;
						xs_reg <= (ext_need[pick] & power_control_reg_reg[dcdma_pkg::POWER_CONTROL_REG_REQ])
							? dcdma_pkg::XS_HOLD : dcdma_pkg::XS_READ;
					end
				end
				dcdma_pkg::XS_HOLD: begin
					tcnt_reg <= 5'h00;
					if (~hld_out & ~bus_hold_ack_s2_reg[0])
						xs_reg <= dcdma_pkg::XS_READ;
				end
				dcdma_pkg::XS_READ: begin
					if (~src_ext_reg && tcnt_reg == 5'h01)
						data_reg <= int_rdata;
					if (src_ext_reg && tcnt_reg == plen - 5'h01)
						data_reg <= p0_s2_reg;
					if (tcnt_reg == plen - 5'h01) begin
						tcnt_reg <= 5'h00;
						xs_reg <= dcdma_pkg::XS_WRITE;
					end
				end
				dcdma_pkg::XS_WRITE: begin
					if (tcnt_reg == plen - 5'h01) begin
						upd_reg <= cur_reg ? 2'b10 : 2'b01;
						xs_reg <= dcdma_pkg::XS_IDLE;
					end
				end
				default: xs_reg <= dcdma_pkg::XS_IDLE;
			endcase
		end
	end

	// Pin and strobe outputs sequenced within each phase
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			port0_out <= 8'h00;
			port0_oe <= 1'b0;
			port2_out <= 8'h00;
			port2_oe <= 1'b0;
			ale <= 1'b0;
			rd_n <= 1'b1;
			wr_n <= 1'b1;
			int_addr <= 8'h00;
			int_sfr_sel <= 1'b0;
			int_rd <= 1'b0;
			int_wr <= 1'b0;
			int_wdata <= 8'h00;
		end else begin
			int_rd <= 1'b0;
			int_wr <= 1'b0;
			ale <= 1'b0;
			if (xs_reg == dcdma_pkg::XS_READ && tcnt_reg == 5'h00) begin
				if (src_ext_reg) begin
					port0_out <= sar_reg[cur_reg][7:0];
					port0_oe <= 1'b1;
					port2_out <= sar_reg[cur_reg][15:8];
					port2_oe <= 1'b1;
					ale <= 1'b1;
				end else begin
					int_addr <= sar_reg[cur_reg][7:0];
					int_sfr_sel <= ~ctrl_reg[cur_reg][dcdma_pkg::CTRL_SRC_INC];
					int_rd <= 1'b1;
				end
			end
			if (xs_reg == dcdma_pkg::XS_READ && src_ext_reg && tcnt_reg == 5'h01) begin
				port0_oe <= 1'b0;
				rd_n <= 1'b0;
			end
			if (xs_reg == dcdma_pkg::XS_READ && tcnt_reg == plen - 5'h01)
				rd_n <= 1'b1;
			if (xs_reg == dcdma_pkg::XS_WRITE && tcnt_reg == 5'h00) begin
				if (dst_ext_reg) begin
					port0_out <= dar_reg[cur_reg][7:0];
					port0_oe <= 1'b1;
					port2_out <= dar_reg[cur_reg][15:8];
					port2_oe <= 1'b1;
					ale <= 1'b1;
				end else begin
					int_addr <= dar_reg[cur_reg][7:0];
					int_sfr_sel <= ~ctrl_reg[cur_reg][dcdma_pkg::CTRL_DST_INC];
					int_wdata <= data_reg;
					int_wr <= 1'b1;
				end
			end
			if (xs_reg == dcdma_pkg::XS_WRITE && dst_ext_reg && tcnt_reg == 5'h01) begin
				port0_out <= data_reg;
				wr_n <= 1'b0;
			end
			if (xs_reg == dcdma_pkg::XS_WRITE && tcnt_reg == plen - 5'h02)
				wr_n <= 1'b1;
			if (xs_reg == dcdma_pkg::XS_WRITE && tcnt_reg == plen - 5'h01) begin
				port0_oe <= 1'b0;
				port2_oe <= 1'b0;
			end
		end
	end

	// Hold handshake, CPU suspension, flag clears and done outputs
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			hld_out <= 1'b1;
			hld_oe <= 1'b0;
			bus_hold_ack_out <= 1'b1;
			bus_hold_ack_oe <= 1'b0;
			hi_seen_reg <= 1'b0;
			grant_reg <= 1'b0;
			cpu_suspend <= 1'b0;
			ser_flag_clr <= 4'h0;
			done_flag <= 2'h0;
		end else begin
			hld_oe <= power_control_reg_reg == 2'h1;
			bus_hold_ack_oe <= power_control_reg_reg == 2'h2;
			if (bus_hold_ack_s2_reg[0])
				hi_seen_reg <= 1'b1;
			else if (xs_reg == dcdma_pkg::XS_READ)
				hi_seen_reg <= 1'b0;
			if (xs_reg == dcdma_pkg::XS_HOLD && hi_seen_reg)
				hld_out <= 1'b0;
			else if (xs_reg == dcdma_pkg::XS_IDLE)
				hld_out <= 1'b1;
			if (~power_control_reg_reg[dcdma_pkg::POWER_CONTROL_REG_ARB] | hld_s2_reg[0])
				grant_reg <= 1'b0;
			else if (~((xs_reg != dcdma_pkg::XS_IDLE) & ext_any))
				grant_reg <= 1'b1;
			bus_hold_ack_out <= ~grant_reg;
			cpu_suspend <= (xs_reg == dcdma_pkg::XS_READ) | (xs_reg == dcdma_pkg::XS_WRITE)
				| (|cont_reg);
			ser_flag_clr <= 4'h0;
			if (|upd_reg && ctrl_reg[cur_reg][dcdma_pkg::CTRL_DEMAND_SEL -: 2]
				== dcdma_pkg::MODE_SERIAL)
				ser_flag_clr <= clr_sel_reg;
			done_flag <= {ctrl_reg[1][dcdma_pkg::CTRL_DONE], ctrl_reg[0][dcdma_pkg::CTRL_DONE]};
		end
	end

	// Checks: clock count per byte
	logic [5:0] xlen_reg;
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst)
			xlen_reg <= 6'h00;
		else if (xs_reg == dcdma_pkg::XS_READ || xs_reg == dcdma_pkg::XS_WRITE)
			xlen_reg <= xlen_reg + 6'h01;
		else
			xlen_reg <= 6'h00;
	end
	AST_ONE_MC: assert property (@(posedge core_clk) disable iff (rst)
		(|upd_reg && !(src_ext_reg && dst_ext_reg)) |-> xlen_reg == 6'd12)
		else $error("single byte did not take twelve clocks");
	AST_TWO_MC: assert property (@(posedge core_clk) disable iff (rst)
		(|upd_reg && src_ext_reg && dst_ext_reg) |-> xlen_reg == 6'd24)
		else $error("external pair byte did not take two machine cycles");
	AST_SRC_INC: assert property (@(posedge core_clk) disable iff (rst)
		(upd_reg[0] && ctrl_reg[0][4]) |=> sar_reg[0] == $past(sar_reg[0]) + 16'h0001)
		else $error("source pointer not incremented");
	AST_DST_KEEP: assert property (@(posedge core_clk) disable iff (rst)
		(upd_reg[1] && !ctrl_reg[1][6]) |=> $stable(dar_reg[1]))
		else $error("destination pointer moved without increment");
	AST_DONE: assert property (@(posedge core_clk) disable iff (rst)
		(upd_reg[0] && bcr_reg[0] == 16'h0001) |=> (ctrl_reg[0][1] && !ctrl_reg[0][0])
		##1 done_flag[0])
		else $error("completion not flagged");
	AST_FLAG_CLR: assert property (@(posedge core_clk) disable iff (rst)
		(|upd_reg && ctrl_reg[cur_reg][3:2] == 2'h2 && |clr_sel_reg) |=> |ser_flag_clr)
		else $error("serial trigger flag not cleared");
	AST_REQ_WAIT: assert property (@(posedge core_clk) disable iff (rst)
		($rose(xs_reg == dcdma_pkg::XS_READ) && ext_any && power_control_reg_reg == 2'h1)
		|-> !hld_out && $past(!bus_hold_ack_s2_reg[0]))
		else $error("external byte began without acknowledge");
	AST_ARB_BLOCK: assert property (@(posedge core_clk) disable iff (rst)
		($rose(xs_reg == dcdma_pkg::XS_READ) && ext_any && power_control_reg_reg == 2'h2)
		|-> $past(hld_s2_reg[0]) && bus_hold_ack_out)
		else $error("external byte began while hold granted");
	AST_PRIO: assert property (@(posedge core_clk) disable iff (rst)
		(start && ready[0]) |=> cur_reg == 1'b0)
		else $error("channel one served before channel zero");
	AST_SUSPEND: assert property (@(posedge core_clk) disable iff (rst)
		(xs_reg == dcdma_pkg::XS_WRITE) |=> cpu_suspend)
		else $error("CPU not suspended during byte");
	COV_BURST: cover property (@(posedge core_clk) disable iff (rst)
		|upd_reg && |cont_reg);
	COV_EXT_PAIR: cover property (@(posedge core_clk) disable iff (rst)
		|upd_reg && src_ext_reg && dst_ext_reg);
	COV_HOLD: cover property (@(posedge core_clk) disable iff (rst)
		xs_reg == dcdma_pkg::XS_HOLD ##1 xs_reg == dcdma_pkg::XS_READ);
	COV_BOTH: cover property (@(posedge core_clk) disable iff (rst) start && &ready);
endmodule : dcdma_top

//--- dcdma_ext_mem.sv
// External data RAM and hold acknowledge responder beside the DMA engine
`timescale 1ns/10ps
module dcdma_ext_mem (
	input wire logic core_clk, // Clock
	input wire logic [7:0] port0_out, // Bus driven by the engine
	input wire logic port0_oe, // Engine drives the bus
	input wire logic ale, // Address latch strobe
	input wire logic rd_n, // Read strobe
	input wire logic wr_n, // Write strobe
	input wire logic hld_out, // Hold request, active low
	output logic [7:0] port0_in, // Bus level seen by the engine
	output logic bus_hold_ack_in // Hold acknowledge, active low
);
	logic [7:0] mem [256];
	logic [7:0] lat_addr = 8'h00;
	logic [7:0] last = 8'h00;
	int dly = 0;
	// Known contents: each byte is its address xor c3
	initial for (int i = 0; i < 256; i++) mem[i] = 8'(i) ^ 8'hc3;
	// Latch address, store on write strobe, remember last read byte
	always @(posedge core_clk) begin
		if (ale) lat_addr <= port0_out;
		if (!wr_n) mem[lat_addr] <= port0_out;
		if (!rd_n) last <= mem[lat_addr];
	end
	// Released bus shows the addressed byte while rd_n is low, otherwise the inverse of the last read byte
	assign port0_in = port0_oe ? port0_out : (!rd_n ? mem[lat_addr] : ~last);
	// Acknowledge a held request after a short delay, drop it on release
	always @(posedge core_clk) begin
		if (hld_out) begin
			bus_hold_ack_in <= 1'b1;
			dly <= 0;
		end else if (dly == 3) begin
			bus_hold_ack_in <= 1'b0;
		end else begin
			dly <= dly + 1;
		end
	end
endmodule : dcdma_ext_mem

//--- dual_channel_dma_with_bus_hold_tb_top.sv
// Self-checking bench for the dual channel DMA engine
`timescale 1ns/10ps
module dual_channel_dma_with_bus_hold_tb_top;
	logic core_clk = 1'b0, rst = 1'b1, avs_read = 1'b0, avs_write = 1'b0, instr_end = 1'b0;
	logic instr_last_mc = 1'b0, hld_in = 1'b1, avs_waitrequest, cpu_suspend, int_sfr_sel;
	logic int_rd, int_wr, port0_oe, port2_oe, ale, rd_n, wr_n, hld_out, hld_oe, bus_hold_ack_in;
	logic bus_hold_ack_out, bus_hold_ack_oe;
	logic [4:0] avs_address = 5'h00;
	logic [31:0] avs_writedata = 32'h0, avs_readdata;
	logic [3:0] ser_flags = 4'h0, ser_set = 4'h0, ser_flag_clr;
	logic [1:0] ext_irq_n = 2'h3, done_flag;
	logic [7:0] int_addr, int_wdata, int_rdata, port0_in, port0_out, port2_out, s, d, q;
	logic [16:0] wq[$];
	int n_errors = 0, checks_done = 0, seed = 43465, cyc = 0;
	dcdma_top uut (.core_clk(core_clk), .rst(rst), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.instr_end(instr_end), .instr_last_mc(instr_last_mc), .cpu_suspend(cpu_suspend),
		.ser_flags(ser_flags), .ser_flag_clr(ser_flag_clr), .ext_irq_n(ext_irq_n),
		.done_flag(done_flag), .int_addr(int_addr), .int_sfr_sel(int_sfr_sel),
		.int_rd(int_rd), .int_wr(int_wr), .int_wdata(int_wdata), .int_rdata(int_rdata),
		.port0_in(port0_in), .port0_out(port0_out), .port0_oe(port0_oe),
		.port2_out(port2_out), .port2_oe(port2_oe), .ale(ale), .rd_n(rd_n), .wr_n(wr_n),
		.hld_in(hld_in), .hld_out(hld_out), .hld_oe(hld_oe), .bus_hold_ack_in(bus_hold_ack_in),
		.bus_hold_ack_out(bus_hold_ack_out), .bus_hold_ack_oe(bus_hold_ack_oe));
	dcdma_ext_mem ram (.core_clk(core_clk), .port0_out(port0_out), .port0_oe(port0_oe),
		.ale(ale), .rd_n(rd_n), .wr_n(wr_n), .hld_out(hld_out), .port0_in(port0_in),
		.bus_hold_ack_in(bus_hold_ack_in));
	// Clock and internal memory contents
	initial forever #20 core_clk = ~core_clk;
	assign int_rdata = int_addr ^ 8'h5a;
	// Instruction boundaries every six clocks while the CPU runs
	always @(posedge core_clk) begin
		cyc <= (cyc == 5) ? 0 : cyc + 1;
		instr_end <= (cyc == 5) && !cpu_suspend;
		instr_last_mc <= (cyc >= 3);
	end
	// Serial flags stay set until the engine clears them; their interrupts stay masked
	always @(posedge core_clk) ser_flags <= (ser_flags & ~ser_flag_clr) | ser_set;
	// Record internal writes as the engine's result stream
	always @(posedge core_clk) if (int_wr === 1'b1) wq.push_back({int_sfr_sel, int_addr, int_wdata});
	task automatic chk(input logic [16:0] g, input logic [16:0] e);
		checks_done++;
		if (g !== e) begin
			n_errors++;
			$display("mismatch at %0t: got %h expected %h", $time, g, e);
		end
	endtask : chk
	// Avalon access: hold the request until waitrequest is seen low
	task automatic bus(input logic [4:0] a, input logic w, input logic [7:0] v);
		avs_address <= a;
		avs_writedata <= {24'h0, v};
		avs_write <= w;
		avs_read <= !w;
		do begin
			@(posedge core_clk);
		end while (avs_waitrequest !== 1'b0);
		q = avs_readdata[7:0];
		avs_write <= 1'b0;
		avs_read <= 1'b0;
		@(posedge core_clk);
	endtask : bus
	// Program one channel, wait for completion, check registers afterwards
	task automatic run(input int ch, input logic [7:0] c, input int cnt);
		logic [4:0] b;
		int n;
		b = 5'(8 * ch);
		wq.delete();
		bus(b, 1'b1, s);
		bus(b + 5'h1, 1'b1, 8'h00);
		bus(b + 5'h2, 1'b1, d);
		bus(b + 5'h3, 1'b1, 8'h00);
		bus(b + 5'h4, 1'b1, 8'(cnt));
		bus(b + 5'h5, 1'b1, 8'h00);
		bus(b + 5'h6, 1'b1, c);
		@(posedge core_clk);
		for (n = 0; n < 4000 && done_flag[ch] !== 1'b1; n++) @(posedge core_clk);
		chk(17'(done_flag[ch]), 17'h1);
		bus(b + 5'h6, 1'b0, 8'h00);
		chk(q, (c & 8'hfe) | 8'h02);
		bus(b + 5'h4, 1'b0, 8'h00);
		chk(q, 17'h0);
		bus(b, 1'b0, 8'h00);
		chk(q, 8'(s + (c[4] ? cnt : 0)));
		bus(b + 5'h2, 1'b0, 8'h00);
		chk(q, 8'(d + (c[6] ? cnt : 0)));
	endtask : run
	task automatic results();
		if (n_errors == 0 && checks_done > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : results
	// Main sequence
	initial begin
		repeat (20) @(posedge core_clk);
		rst <= 1'b0;
		@(posedge core_clk);
		bus(dcdma_pkg::REG_CTRL, 1'b0, 8'h00);
		chk(q, dcdma_pkg::CTRL_RESET);
		bus(5'h1f, 1'b0, 8'h00);
		chk(q, 17'h0);
		bus(dcdma_pkg::REG_POWER_CTRL, 1'b1, 8'h01);
		bus(dcdma_pkg::REG_POWER_CTRL, 1'b0, 8'h00);
		chk(q, 17'h1);
		// Burst, external RAM to external RAM through the hold handshake
		s = 8'($random(seed)) | 8'h80;
		d = 8'h10;
		run(0, 8'h55, 3);
		for (int i = 0; i < 3; i++) chk(ram.mem[8'(d + i)], 8'(s + i) ^ 8'hc3);
		// Alternate cycles, fixed external byte to a fixed SFR
		s = 8'h80;
		d = 8'($random(seed));
		run(1, 8'h81, 2);
		for (int i = 0; i < 2; i++) chk(wq[i], {1'b1, d, 8'h80 ^ 8'hc3});
		// Pin demand, level held low, internal RAM to internal RAM
		ext_irq_n <= 2'b10;
		s = 8'($random(seed));
		d = 8'($random(seed));
		run(0, 8'hfd, 2);
		ext_irq_n <= 2'b11;
		for (int i = 0; i < 2; i++) chk(wq[i], {1'b0, 8'(d + i), 8'(s + i) ^ 8'h5a});
		// Serial demand, two flags each move one byte and are cleared
		s = 8'($random(seed));
		d = 8'($random(seed));
		ser_set <= 4'h5;
		@(posedge core_clk);
		ser_set <= 4'h0;
		run(0, 8'hf9, 2);
		chk(17'(ser_flags), 17'h0);
		for (int i = 0; i < 2; i++) chk(wq[i], {1'b0, 8'(d + i), 8'(s + i) ^ 8'h5a});
		// Arbiter role, an outside hold stalls external bytes until released
		bus(dcdma_pkg::REG_POWER_CTRL, 1'b1, 8'h02);
		hld_in <= 1'b0;
		repeat (10) @(posedge core_clk);
		chk(17'({cpu_suspend, bus_hold_ack_oe, bus_hold_ack_out}), 17'h2);
		s = 8'($random(seed));
		d = 8'h40;
		fork
			run(1, 8'h71, 2);
			begin
				repeat (150) @(posedge core_clk);
				chk(ram.mem[d], d ^ 8'hc3);
				hld_in <= 1'b1;
			end
		join
		chk(17'({bus_hold_ack_oe, bus_hold_ack_out}), 17'h3);
		for (int i = 0; i < 2; i++) chk(ram.mem[8'(d + i)], 8'(s + i) ^ 8'h5a);
		// Pin one edge sensitive, each falling edge moves exactly one byte
		bus(dcdma_pkg::REG_EXT_CFG, 1'b1, 8'h02);
		s = 8'($random(seed));
		d = 8'($random(seed));
		fork
			run(1, 8'hfd, 2);
			for (int p = 1; p <= 2; p++) begin
				repeat (40) @(posedge core_clk);
				ext_irq_n[1] <= 1'b0;
				repeat (40) @(posedge core_clk);
				ext_irq_n[1] <= 1'b1;
				chk(17'(wq.size()), 17'(p));
			end
		join
		for (int i = 0; i < 2; i++) chk(wq[i], {1'b0, 8'(d + i), 8'(s + i) ^ 8'h5a});
		results();
	end
	// Watchdog
	initial begin
		#(40 * 20000);
		n_errors++;
		results();
	end
endmodule : dual_channel_dma_with_bus_hold_tb_top
